// file: rtl/slc_pkg.sv
// constants and types for the serial segment lcd controller
// How it works
// - 32x4 display memory, word drives one column
// - mode id 110 read, 101 write, 100 command
// - successive commands need no repeated id
// - select high resets serial interface and mode
// - write strobe rising edge samples data line
// - read strobe falling edge drives next bit
// - address A5..A0 then data D0..D3
// - address advances after every further nibble
// - commands halt and run the system oscillator
// - bias off blanks display, bias on enables
// - panel command picks bias and backplane count
// - clock source is rc, crystal or external
// - halt stops clocks, display, tone and alert unless external clock; serial interface keeps working
// - power-on halted with alert output disabled
// - lcd drive clock is always 256 hz
// - 256k prescaled to 32k, then divided 2^n
// - 8-stage time base plus 2-stage watchdog
// - flag commands gate time base and route alert
// - watchdog clear clears both, timer clear one
// - watchdog timeout holds alert low until cleared
// - alert enable shows source, disable floats pin
// - tone pair 4k or 2k, low when off
package slc_pkg;
  localparam int SLC_WORDS = 32;
  localparam int SLC_ADDR_W = 6;
  localparam int SLC_NIB_W = 4;
  localparam int SLC_CMD_BITS = 9;
  localparam int SLC_MODE_BITS = 3;
  localparam int SLC_PRE_LOG2 = 3;
  localparam int SLC_DIV_W = 7;
  localparam int SLC_TONE_HI_BIT = 2;
  localparam int SLC_TONE_LO_BIT = 3;
  localparam int SLC_NPINS = 7;
  localparam logic [6:0] SLC_PIN_IDLE = 7'h78;
  localparam logic [2:0] SLC_ID_READ = 3'h6;
  localparam logic [2:0] SLC_ID_WRITE = 3'h5;
  localparam logic [2:0] SLC_ID_CMD = 3'h4;
  localparam logic [7:0] SLC_C_HALT = 8'h00;
  localparam logic [7:0] SLC_C_RUN = 8'h01;
  localparam logic [7:0] SLC_C_BIAS_OFF = 8'h02;
  localparam logic [7:0] SLC_C_BIAS_ON = 8'h03;
  localparam logic [7:0] SLC_C_TB_OUT_OFF = 8'h04;
  localparam logic [7:0] SLC_C_WDT_OFF = 8'h05;
  localparam logic [7:0] SLC_C_TB_OUT_ON = 8'h06;
  localparam logic [7:0] SLC_C_WDT_ON = 8'h07;
  localparam logic [7:0] SLC_C_TONE_OFF = 8'h08;
  localparam logic [7:0] SLC_C_TONE_ON = 8'h09;
  localparam logic [7:0] SLC_C_TB_CLR = 8'h0c;
  localparam logic [7:0] SLC_C_WDT_CLR = 8'h0e;
  localparam logic [7:0] SLC_C_XTAL = 8'h14;
  localparam logic [7:0] SLC_C_RC = 8'h18;
  localparam logic [7:0] SLC_C_EXT = 8'h1c;
  localparam logic [7:0] SLC_C_PANEL = 8'h20;
  localparam logic [7:0] SLC_C_BEEP_HI = 8'h40;
  localparam logic [7:0] SLC_C_BEEP_LO = 8'h60;
  localparam logic [7:0] SLC_C_ALERT_ON = 8'h88;
  localparam logic [7:0] SLC_C_ALERT_OFF = 8'h80;
  localparam logic [7:0] SLC_M_ALL = 8'hff;
  localparam logic [7:0] SLC_M_HI7 = 8'hfe;
  localparam logic [7:0] SLC_M_HI6 = 8'hfc;
  localparam logic [7:0] SLC_M_HI4 = 8'hf0;
  localparam logic [7:0] SLC_M_HI3 = 8'he0;
  localparam logic [1:0] SLC_AB_BAD = 2'h3;
  localparam logic [1:0] SLC_AB_RESET = 2'h0;
  localparam logic [2:0] SLC_MIN_COMS = 3'h2;

  typedef enum logic [1:0] {
    SLC_SRC_RC = 2'h0,
    SLC_SRC_XTAL = 2'h1,
    SLC_SRC_EXT = 2'h2
  } slc_src_t;

  typedef enum logic [4:0] {
    SLC_ST_MODE = 5'h01,
    SLC_ST_ADDR = 5'h02,
    SLC_ST_DATA = 5'h04,
    SLC_ST_CMD = 5'h08,
    SLC_ST_SKIP = 5'h10
  } slc_state_t;

  function automatic logic slc_hit(input logic [7:0] code, input logic [7:0] pat,
                                   input logic [7:0] care);
    slc_hit = ((code ^ pat) & care) == 8'h00;
  endfunction
endpackage

// file: rtl/slc_clkgen.sv
// prescaler and divider chain for time base, lcd and tone clocks
`timescale 1ns/100ps
module slc_clkgen
  import slc_pkg::*;
#(
  parameter int PRE_LOG2 = SLC_PRE_LOG2
)
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic src_tick_i,
  input wire logic src_fast_i,
  input wire logic run_i,
  input wire logic [2:0] rate_i,
  output logic base_tick_o,
  output logic tb_tick_o,
  output logic lcd_tick_o,
  output logic tone_hi_o,
  output logic tone_lo_o
);
  logic [PRE_LOG2-1:0] pre_reg;
  logic [SLC_DIV_W-1:0] div_reg;
  logic [SLC_DIV_W-1:0] rate_mask;

  // 256k sources divided by eight
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      pre_reg <= '0;
    else if (run_i && src_tick_i && src_fast_i)
      pre_reg <= pre_reg + 1'b1;
  end

  assign base_tick_o = run_i && src_tick_i && (!src_fast_i || (&pre_reg));

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      div_reg <= '0;
    else if (base_tick_o)
      div_reg <= div_reg + 1'b1;
  end

  assign rate_mask = SLC_DIV_W'((1 << rate_i) - 1);
  assign tb_tick_o = base_tick_o && ((div_reg & rate_mask) == rate_mask);
  assign lcd_tick_o = base_tick_o && (&div_reg);
  assign tone_hi_o = div_reg[SLC_TONE_HI_BIT];
  assign tone_lo_o = div_reg[SLC_TONE_LO_BIT];
endmodule // slc_clkgen

// file: rtl/slc_core.sv
// serial segment lcd controller core
`timescale 1ns/100ps
module slc_core
  import slc_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic cs_n_i,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  input wire logic data_i,
  output logic data_o,
  output logic data_oe_n_o,
  input wire logic rc_osc_i,
  input wire logic xtal_input_pad_i,
  input wire logic ext_clk_i,
  input wire logic [2:0] tb_rate_i,
  output logic alert_o,
  output logic alert_oe_n_o,
  output logic [1:0] tone_out_pair_o,
  output logic [3:0] backplane_drive_o,
  output logic [SLC_WORDS-1:0] column_drive_o,
  output logic bias_enable_o,
  output logic bias_third_o,
  output logic [1:0] panel_ab_o,
  output logic sys_running_o,
  output logic [1:0] clk_source_o
);
  logic [SLC_NPINS-1:0] pin_s1_reg;
  logic [SLC_NPINS-1:0] pin_s2_reg;
  logic [SLC_NPINS-1:0] pin_s3_reg;
  logic cs_n_s;
  logic data_s;
  logic wr_rise;
  logic rd_fall;
  logic [2:0] osc_rise;
  slc_state_t state_reg;
  logic [3:0] cnt_reg;
  logic [SLC_CMD_BITS-2:0] shift_reg;
  logic [2:0] mode_reg;
  logic [SLC_ADDR_W-1:0] addr_reg;
  logic [1:0] wbit_reg;
  logic [1:0] rbit_reg;
  logic [SLC_NIB_W-2:0] wdat_reg;
  logic [SLC_NIB_W-1:0] mem [SLC_WORDS];
  logic [4:0] widx;
  logic mem_we;
  logic cmd_fire;
  logic [7:0] cmd_code;
  logic halted_reg;
  logic bias_on_reg;
  logic bias_third_reg;
  logic [1:0] ab_reg;
  slc_src_t src_reg;
  logic tone_on_reg;
  logic tone_hi_reg;
  logic tb_en_reg;
  logic route_tb_reg;
  logic route_wdt_reg;
  logic alert_en_reg;
  logic [7:0] tb_reg;
  logic [1:0] wdt_reg;
  logic wdt_flag_reg;
  logic running;
  logic display_on;
  logic src_tick;
  logic base_tick;
  logic tb_tick;
  logic lcd_tick;
  logic tone_hi;
  logic tone_lo;
  logic tone_sq;
  logic [1:0] com_reg;
  logic [2:0] com_count;
  logic clr_tb;
  logic watchdog_clear_cmd;
  logic alert_low;

  // pin synchronisers, third stage only for edges
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pin_s1_reg <= SLC_PIN_IDLE;
      pin_s2_reg <= SLC_PIN_IDLE;
      pin_s3_reg <= SLC_PIN_IDLE;
    end
    else
    begin
      pin_s1_reg <= {cs_n_i, wr_n_i, rd_n_i, data_i, rc_osc_i, xtal_input_pad_i, ext_clk_i};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  assign cs_n_s = pin_s2_reg[6];
  assign data_s = pin_s2_reg[3];
  assign wr_rise = !cs_n_s && pin_s2_reg[5] && !pin_s3_reg[5];
  assign rd_fall = !cs_n_s && !pin_s2_reg[4] && pin_s3_reg[4];
  assign osc_rise = pin_s2_reg[2:0] & ~pin_s3_reg[2:0];

  // serial session sequencer
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_reg <= SLC_ST_MODE;
      cnt_reg <= '0;
      shift_reg <= '0;
      mode_reg <= '0;
      addr_reg <= '0;
      wbit_reg <= '0;
      rbit_reg <= '0;
      wdat_reg <= '0;
    end
    else if (cs_n_s)
    begin
      state_reg <= SLC_ST_MODE;
      cnt_reg <= '0;
      wbit_reg <= '0;
      rbit_reg <= '0;
    end
    else
    begin
      case (state_reg)
        SLC_ST_MODE:
          if (wr_rise)
          begin
            shift_reg <= {shift_reg[SLC_CMD_BITS-3:0], data_s};
            cnt_reg <= cnt_reg + 1'b1;
            if (cnt_reg == 4'(SLC_MODE_BITS - 1))
            begin
              mode_reg <= {shift_reg[1:0], data_s};
              cnt_reg <= '0;
              case ({shift_reg[1:0], data_s})
                SLC_ID_READ, SLC_ID_WRITE: state_reg <= SLC_ST_ADDR;
                SLC_ID_CMD: state_reg <= SLC_ST_CMD;
                default: state_reg <= SLC_ST_SKIP;
              endcase
            end
          end
        SLC_ST_ADDR:
          if (wr_rise)
          begin
            addr_reg <= {addr_reg[SLC_ADDR_W-2:0], data_s};
            cnt_reg <= cnt_reg + 1'b1;
            if (cnt_reg == 4'(SLC_ADDR_W - 1))
            begin
              cnt_reg <= '0;
              state_reg <= SLC_ST_DATA;
            end
          end
        SLC_ST_DATA:
        begin
          if (wr_rise && mode_reg == SLC_ID_WRITE)
          begin
            wbit_reg <= wbit_reg + 1'b1;
            if (wbit_reg == 2'(SLC_NIB_W - 1))
              addr_reg <= addr_reg + 1'b1;
            else
              wdat_reg[wbit_reg] <= data_s;
          end
          else if (rd_fall)
          begin
            rbit_reg <= rbit_reg + 1'b1;
            if (mode_reg == SLC_ID_READ && rbit_reg == 2'(SLC_NIB_W - 1))
              addr_reg <= addr_reg + 1'b1;
          end
        end
        SLC_ST_CMD:
          if (wr_rise)
          begin
            shift_reg <= {shift_reg[SLC_CMD_BITS-3:0], data_s};
            cnt_reg <= cnt_reg + 1'b1;
            if (cnt_reg == 4'(SLC_CMD_BITS - 1))
              cnt_reg <= '0;
          end
        SLC_ST_SKIP: cnt_reg <= '0;
        default: state_reg <= SLC_ST_MODE;
      endcase
    end
  end

  assign cmd_fire = !cs_n_s && wr_rise && state_reg == SLC_ST_CMD
                    && cnt_reg == 4'(SLC_CMD_BITS - 1);
  assign cmd_code = shift_reg;
  assign mem_we = !cs_n_s && wr_rise && state_reg == SLC_ST_DATA && mode_reg == SLC_ID_WRITE
                  && wbit_reg == 2'(SLC_NIB_W - 1);
  assign widx = addr_reg[4:0];

  // display memory
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      for (int i = 0; i < SLC_WORDS; i++)
        mem[i] <= '0;
    end
    else if (mem_we)
      mem[widx] <= {data_s, wdat_reg};
  end

  // read data driver
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      data_o <= 1'b1;
      data_oe_n_o <= 1'b1;
    end
    else if (cs_n_s || (wr_rise && state_reg != SLC_ST_MODE))
      data_oe_n_o <= 1'b1;
    else if (rd_fall && state_reg == SLC_ST_DATA)
    begin
      data_o <= mem[widx][rbit_reg];
      data_oe_n_o <= 1'b0;
    end
  end

  assign running = !halted_reg || src_reg == SLC_SRC_EXT;
  assign display_on = bias_on_reg && running;

  // command execution
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      halted_reg <= 1'b1;
      bias_on_reg <= 1'b0;
      bias_third_reg <= 1'b0;
      ab_reg <= SLC_AB_RESET;
      src_reg <= SLC_SRC_RC;
      tone_on_reg <= 1'b0;
      tone_hi_reg <= 1'b1;
      tb_en_reg <= 1'b0;
      route_tb_reg <= 1'b0;
      route_wdt_reg <= 1'b0;
      alert_en_reg <= 1'b0;
    end
    else if (cmd_fire)
    begin
      if (slc_hit(cmd_code, SLC_C_HALT, SLC_M_ALL) && src_reg != SLC_SRC_EXT)
      begin
        halted_reg <= 1'b1;
        bias_on_reg <= 1'b0;
      end
      if (slc_hit(cmd_code, SLC_C_RUN, SLC_M_ALL))
        halted_reg <= 1'b0;
      if (slc_hit(cmd_code, SLC_C_BIAS_OFF, SLC_M_ALL))
        bias_on_reg <= 1'b0;
      if (slc_hit(cmd_code, SLC_C_BIAS_ON, SLC_M_ALL))
        bias_on_reg <= 1'b1;
      if (slc_hit(cmd_code, SLC_C_TB_OUT_OFF, SLC_M_ALL))
        route_tb_reg <= 1'b0;
      if (slc_hit(cmd_code, SLC_C_WDT_OFF, SLC_M_ALL))
      begin
        tb_en_reg <= 1'b0;
        route_wdt_reg <= 1'b0;
      end
      if (slc_hit(cmd_code, SLC_C_TB_OUT_ON, SLC_M_ALL))
      begin
        tb_en_reg <= 1'b1;
        route_tb_reg <= 1'b1;
        route_wdt_reg <= 1'b0;
      end
      if (slc_hit(cmd_code, SLC_C_WDT_ON, SLC_M_ALL))
      begin
        tb_en_reg <= 1'b1;
        route_wdt_reg <= 1'b1;
        route_tb_reg <= 1'b0;
      end
      if (slc_hit(cmd_code, SLC_C_TONE_OFF, SLC_M_ALL))
        tone_on_reg <= 1'b0;
      if (slc_hit(cmd_code, SLC_C_TONE_ON, SLC_M_ALL))
        tone_on_reg <= 1'b1;
      if (slc_hit(cmd_code, SLC_C_XTAL, SLC_M_HI6))
        src_reg <= SLC_SRC_XTAL;
      if (slc_hit(cmd_code, SLC_C_RC, SLC_M_HI6))
        src_reg <= SLC_SRC_RC;
      if (slc_hit(cmd_code, SLC_C_EXT, SLC_M_HI6))
        src_reg <= SLC_SRC_EXT;
      if (slc_hit(cmd_code, SLC_C_PANEL, SLC_M_HI4) && cmd_code[3:2] != SLC_AB_BAD)
      begin
        ab_reg <= cmd_code[3:2];
        bias_third_reg <= cmd_code[0];
      end
      if (slc_hit(cmd_code, SLC_C_BEEP_HI, SLC_M_HI3))
      begin
        tone_hi_reg <= 1'b1;
        tone_on_reg <= 1'b1;
      end
      if (slc_hit(cmd_code, SLC_C_BEEP_LO, SLC_M_HI4))
      begin
        tone_hi_reg <= 1'b0;
        tone_on_reg <= 1'b1;
      end
      if (slc_hit(cmd_code, SLC_C_ALERT_ON, SLC_M_ALL))
        alert_en_reg <= 1'b1;
      if (slc_hit(cmd_code, SLC_C_ALERT_OFF, SLC_M_ALL))
        alert_en_reg <= 1'b0;
    end
  end

  // selected clock source ticks
  always_comb
  begin
    case (src_reg)
      SLC_SRC_XTAL: src_tick = osc_rise[1];
      SLC_SRC_EXT: src_tick = osc_rise[0];
      default: src_tick = osc_rise[2];
    endcase
  end

  slc_clkgen u_clkgen (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .src_tick_i(src_tick),
    .src_fast_i(src_reg != SLC_SRC_XTAL),
    .run_i(running),
    .rate_i(tb_rate_i),
    .base_tick_o(base_tick),
    .tb_tick_o(tb_tick),
    .lcd_tick_o(lcd_tick),
    .tone_hi_o(tone_hi),
    .tone_lo_o(tone_lo)
  );

  assign watchdog_clear_cmd = cmd_fire && slc_hit(cmd_code, SLC_C_WDT_CLR, SLC_M_HI7);
  assign clr_tb = cmd_fire && slc_hit(cmd_code, SLC_C_TB_CLR, SLC_M_HI6);

  // time base and watchdog stages
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      tb_reg <= '0;
      wdt_reg <= '0;
    end
    else if (clr_tb)
    begin
      tb_reg <= '0;
      if (watchdog_clear_cmd)
        wdt_reg <= '0;
    end
    else if (tb_tick && tb_en_reg)
    begin
      tb_reg <= tb_reg + 1'b1;
      if (&tb_reg)
        wdt_reg <= wdt_reg + 1'b1;
    end
  end

  // watchdog flag, a timeout wins over a clear in the same cycle
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      wdt_flag_reg <= 1'b0;
    else if (tb_tick && tb_en_reg && (&tb_reg) && (&wdt_reg))
      wdt_flag_reg <= 1'b1;
    else if (watchdog_clear_cmd || (cmd_fire && slc_hit(cmd_code, SLC_C_ALERT_OFF, SLC_M_ALL)))
      wdt_flag_reg <= 1'b0;
  end

  assign alert_low = alert_en_reg && running
                     && ((route_wdt_reg && wdt_flag_reg)
                     || (route_tb_reg && tb_reg[7]));

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      alert_oe_n_o <= 1'b1;
    else
      alert_oe_n_o <= !alert_low;
  end

  assign alert_o = 1'b0;

  // backplane scan at 256 hz
  assign com_count = 3'(ab_reg) + SLC_MIN_COMS;
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      com_reg <= '0;
    else if (lcd_tick)
      com_reg <= (3'(com_reg) + 3'h1 >= com_count) ? 2'h0 : com_reg + 1'b1;
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      backplane_drive_o <= '0;
      column_drive_o <= '0;
    end
    else
    begin
      backplane_drive_o <= display_on ? 4'(4'h1 << com_reg) : 4'h0;
      for (int i = 0; i < SLC_WORDS; i++)
        column_drive_o[i] <= display_on && mem[i][com_reg];
    end
  end

  // tone pair
  assign tone_sq = tone_hi_reg ? tone_hi : tone_lo;
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      tone_out_pair_o <= 2'h0;
    else if (tone_on_reg && running)
      tone_out_pair_o <= {tone_sq, !tone_sq};
    else
      tone_out_pair_o <= 2'h0;
  end

  assign bias_enable_o = display_on;
  assign bias_third_o = bias_third_reg;
  assign panel_ab_o = ab_reg;
  assign sys_running_o = running;
  assign clk_source_o = src_reg;
endmodule // slc_core

// file: tb/slc_core_monitor.sv
// port assertions for the serial segment lcd controller
`timescale 1ns/100ps
module slc_core_monitor (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic data_o,
  input wire logic data_oe_n_o,
  input wire logic alert_o,
  input wire logic alert_oe_n_o,
  input wire logic [1:0] tone_out_pair_o,
  input wire logic [3:0] backplane_drive_o,
  input wire logic bias_enable_o,
  input wire logic bias_third_o,
  input wire logic [1:0] panel_ab_o,
  input wire logic sys_running_o,
  input wire logic [1:0] clk_source_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  AST_CS_RELEASE: assert property (cs_n_i [*6] |-> data_oe_n_o)
    else $error("data pin driven while deselected");
  AST_CFG_QUIET: assert property (cs_n_i [*6] |=> $stable(panel_ab_o) &&
    $stable(bias_third_o) && $stable(clk_source_o) && $stable(sys_running_o))
    else $error("configuration changed while deselected");
  AST_OE_AFTER_RD: assert property ($fell(data_oe_n_o) |-> !rd_n_i && !cs_n_i)
    else $error("data pin driven without read strobe");
  AST_RD_HOLD: assert property (rd_n_i [*6] |-> $stable(data_o))
    else $error("read data moved while strobe high");
  AST_TONE_PAIR: assert property (tone_out_pair_o != 2'h3)
    else $error("tone outputs not complementary");
  AST_TONE_HALT: assert property (!sys_running_o [*2] |-> tone_out_pair_o == 2'h0)
    else $error("tone active while halted");
  AST_HALT_BIAS: assert property (!sys_running_o |-> !bias_enable_o)
    else $error("bias on while halted");
  AST_BLANK_BP: assert property (!bias_enable_o [*2] |-> backplane_drive_o == 4'h0)
    else $error("backplane active while blank");
  AST_BP_ONEHOT: assert property ($onehot0(backplane_drive_o))
    else $error("more than one backplane active");
  AST_ALERT_OD: assert property (alert_o == 1'b0)
    else $error("alert pin driven high");
  AST_ALERT_HALT: assert property (!sys_running_o [*2] |-> alert_oe_n_o)
    else $error("alert pulled low while halted");
  AST_AB_VALID: assert property (panel_ab_o != 2'h3)
    else $error("reserved backplane count taken");
endmodule // slc_core_monitor

bind slc_core slc_core_monitor mon (.clock_i(clock_i), .resetn_i(resetn_i),
  .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .data_o(data_o), .data_oe_n_o(data_oe_n_o),
  .alert_o(alert_o), .alert_oe_n_o(alert_oe_n_o), .tone_out_pair_o(tone_out_pair_o),
  .backplane_drive_o(backplane_drive_o), .bias_enable_o(bias_enable_o),
  .bias_third_o(bias_third_o), .panel_ab_o(panel_ab_o), .sys_running_o(sys_running_o),
  .clk_source_o(clk_source_o));

// file: tb/slc_host_model.sv
// host model driving the serial strobe link
`timescale 1ns/100ps
module slc_host_model (
  input wire logic clock_i,
  input wire logic line_i,
  output logic cs_n_o,
  output logic wr_n_o,
  output logic rd_n_o,
  output logic data_o,
  output logic data_oe_n_o
);
  initial
  begin
    cs_n_o = 1'b1;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    data_o = 1'b1;
    data_oe_n_o = 1'b1;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  // data held over the rising strobe edge
  task automatic bit_w(input logic b);
    data_o = b;
    data_oe_n_o = 1'b0;
    wr_n_o = 1'b0;
    tk(5);
    wr_n_o = 1'b1;
    tk(5);
  endtask
  task automatic open_mode(input logic [2:0] id);
    cs_n_o = 1'b0;
    tk(5);
    for (int i = 2; i >= 0; i--)
      bit_w(id[i]);
  endtask
  task automatic close_mode();
    cs_n_o = 1'b1;
    data_oe_n_o = 1'b1;
    tk(5);
  endtask
  task automatic send_addr(input logic [5:0] a);
    for (int i = 5; i >= 0; i--)
      bit_w(a[i]);
  endtask
  task automatic send_nib(input logic [3:0] n);
    for (int i = 0; i < 4; i++)
      bit_w(n[i]);
  endtask
  task automatic send_cmd(input logic [7:0] c);
    for (int i = 7; i >= 0; i--)
      bit_w(c[i]);
    bit_w(1'b1);
  endtask
  // line released, sampled while strobe high
  task automatic read_nib(output logic [3:0] n);
    data_oe_n_o = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      rd_n_o = 1'b0;
      tk(5);
      rd_n_o = 1'b1;
      tk(2);
      n[i] = line_i;
      tk(3);
    end
  endtask
endmodule // slc_host_model

// file: tb/segment_lcd_serial_controller_tb_top.sv
// testbench for the serial segment lcd controller
`timescale 1ns/100ps
module segment_lcd_serial_controller_tb_top;
  import slc_pkg::*;
  logic clock_i, resetn_i, cs_n, wr_n, rd_n, h_d, h_oe_n, line, d_o, d_oe_n;
  logic osc_rc, osc_xt, osc_ext;
  int osc_cnt;
  logic alert, alert_oe_n, bias_en, bias_third, running;
  logic [2:0] tb_rate;
  logic [1:0] tone, ab, src;
  logic [3:0] bp;
  logic [31:0] cols;
  int num_errors;
  int compares;
  // pull-up on the shared data pin
  assign line = !d_oe_n ? d_o : (!h_oe_n ? h_d : 1'b1);
  slc_core dut (.clock_i(clock_i), .resetn_i(resetn_i), .cs_n_i(cs_n), .wr_n_i(wr_n),
    .rd_n_i(rd_n), .data_i(line), .data_o(d_o), .data_oe_n_o(d_oe_n), .rc_osc_i(osc_rc),
    .xtal_input_pad_i(osc_xt), .ext_clk_i(osc_ext), .tb_rate_i(tb_rate), .alert_o(alert),
    .alert_oe_n_o(alert_oe_n), .tone_out_pair_o(tone), .backplane_drive_o(bp),
    .column_drive_o(cols), .bias_enable_o(bias_en), .bias_third_o(bias_third),
    .panel_ab_o(ab), .sys_running_o(running), .clk_source_o(src));
  slc_host_model host (.clock_i(clock_i), .line_i(line), .cs_n_o(cs_n), .wr_n_o(wr_n),
    .rd_n_o(rd_n), .data_o(h_d), .data_oe_n_o(h_oe_n));
  initial
  begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  initial
  begin
    osc_cnt = 0;
    forever
    begin
      @(posedge clock_i);
      #1;
      osc_cnt++;
    end
  end
  // three free-running oscillator pins at different rates
  assign osc_rc = (osc_cnt % 10) >= 5;
  assign osc_xt = (osc_cnt % 6) >= 3;
  assign osc_ext = (osc_cnt % 8) >= 4;
  task automatic report_and_stop();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // active backplane against the column bits of the two written words
  task automatic chk_scan();
    logic [7:0] exp;
    exp = 8'hff;
    for (int k = 0; k < 4; k++)
      if (bp === 4'(4'h1 << k))
        exp = {4'(4'h1 << k), 2'h0, 1'(4'h3 >> k), 1'(4'ha >> k)};
    chk({bp, 2'h0, cols[31:30]}, exp);
    chk({7'h0, |cols[29:0]}, 8'h00);
  endtask
  task automatic t_mem();
    logic [3:0] n;
    host.open_mode(SLC_ID_WRITE);
    host.send_addr(6'h1e);
    host.send_nib(4'ha);
    host.send_nib(4'h3);
    host.close_mode();
    host.open_mode(SLC_ID_READ);
    host.send_addr(6'h1e);
    host.read_nib(n);
    chk({4'h0, n}, 8'h0a);
    host.read_nib(n);
    chk({4'h0, n}, 8'h03);
    host.close_mode();
  endtask
  // partial nibble dropped, strobes while deselected ignored
  task automatic t_abort();
    logic [3:0] n;
    host.open_mode(SLC_ID_WRITE);
    host.send_addr(6'h1e);
    host.bit_w(1'b1);
    host.bit_w(1'b1);
    host.close_mode();
    for (int i = 0; i < 13; i++)
      host.bit_w(i[0]);
    host.open_mode(3'h7);
    host.send_addr(6'h1e);
    host.send_nib(4'h5);
    host.close_mode();
    host.open_mode(SLC_ID_READ);
    host.send_addr(6'h1e);
    host.read_nib(n);
    chk({4'h0, n}, 8'h0a);
    host.close_mode();
  endtask
  task automatic t_cmds();
    host.open_mode(SLC_ID_CMD);
    host.send_cmd(SLC_C_RUN);
    host.send_cmd(SLC_C_BIAS_ON);
    host.send_cmd(8'h29);
    host.send_cmd(SLC_C_XTAL);
    chk({6'h0, running, bias_en}, 8'h03);
    chk({5'h0, bias_third, ab}, 8'h06);
    chk({6'h0, src}, 8'h01);
    chk_scan();
    host.send_cmd(8'h0a);
    host.send_cmd(8'h2c);
    chk({5'h0, bias_third, ab}, 8'h06);
    host.send_cmd(SLC_C_EXT);
    host.send_cmd(SLC_C_HALT);
    chk({5'h0, running, src}, 8'h06);
    host.send_cmd(SLC_C_RC);
    host.send_cmd(SLC_C_HALT);
    chk({5'h0, running, bias_en, src[0]}, 8'h00);
    host.send_cmd(SLC_C_BIAS_OFF);
    host.send_cmd(SLC_C_RUN);
    chk({6'h0, running, bias_en}, 8'h02);
    chk({bp, 3'h0, |cols}, 8'h00);
  endtask
  task automatic tone_win(input int n, input logic on);
    logic [1:0] seen;
    seen = 2'b00;
    repeat (n)
    begin
      host.tk(1);
      if (tone === 2'b10) seen[1] = 1'b1;
      if (tone === 2'b01) seen[0] = 1'b1;
    end
    chk({6'h0, seen}, on ? 8'h03 : 8'h00);
  endtask
  task automatic t_tone();
    host.send_cmd(SLC_C_BEEP_HI);
    tone_win(1400, 1'b1);
    host.send_cmd(SLC_C_BEEP_LO);
    tone_win(2800, 1'b1);
    host.send_cmd(SLC_C_TONE_OFF);
    tone_win(1400, 1'b0);
    host.send_cmd(SLC_C_TONE_ON);
    tone_win(2800, 1'b1);
    host.send_cmd(SLC_C_HALT);
    tone_win(1400, 1'b0);
    host.send_cmd(SLC_C_RUN);
  endtask
  task automatic t_alert();
    int i;
    host.send_cmd(SLC_C_TB_CLR);
    host.send_cmd(SLC_C_TB_OUT_ON);
    host.send_cmd(SLC_C_ALERT_ON);
    i = 0;
    while (alert_oe_n !== 1'b0 && i < 12000)
    begin
      host.tk(1);
      i++;
    end
    chk({7'h0, alert_oe_n}, 8'h00);
    host.send_cmd(SLC_C_TB_CLR);
    chk({7'h0, alert_oe_n}, 8'h01);
    host.send_cmd(SLC_C_WDT_CLR);
    host.send_cmd(SLC_C_WDT_ON);
    host.send_cmd(SLC_C_WDT_OFF);
    host.send_cmd(SLC_C_TB_OUT_OFF);
    host.send_cmd(SLC_C_ALERT_OFF);
    chk({7'h0, alert_oe_n}, 8'h01);
    host.close_mode();
  endtask
  // watchdog timeout on the alert pin, crystal source at rate 1
  task automatic t_wdt();
    int i;
    tb_rate = 3'h1;
    host.open_mode(SLC_ID_CMD);
    host.send_cmd(SLC_C_XTAL);
    host.send_cmd(SLC_C_WDT_CLR);
    host.send_cmd(SLC_C_WDT_ON);
    host.send_cmd(SLC_C_ALERT_ON);
    host.tk(9000);
    chk({7'h0, alert_oe_n}, 8'h01);
    i = 0;
    while (alert_oe_n !== 1'b0 && i < 6000)
    begin
      host.tk(1);
      i++;
    end
    chk({7'h0, alert_oe_n}, 8'h00);
    host.tk(300);
    chk({7'h0, alert_oe_n}, 8'h00);
    host.send_cmd(SLC_C_WDT_CLR);
    chk({7'h0, alert_oe_n}, 8'h01);
    host.send_cmd(SLC_C_WDT_OFF);
    host.send_cmd(SLC_C_ALERT_OFF);
    host.close_mode();
  endtask
  // second reset in mid-run returns to the halted power-on state
  task automatic t_reset();
    resetn_i = 1'b0;
    host.tk(2);
    resetn_i = 1'b1;
    host.tk(3);
    chk({6'h0, running, alert_oe_n}, 8'h01);
    chk({4'h0, tone, src}, 8'h00);
    chk({bp, 3'h0, |cols}, 8'h00);
  endtask
  initial
  begin
    num_errors = 0;
    compares = 0;
    tb_rate = 3'h0;
    resetn_i = 1'b0;
    repeat (5) @(posedge clock_i);
    #1;
    resetn_i = 1'b1;
    host.tk(3);
    chk({6'h0, running, alert_oe_n}, 8'h01);
    chk({4'h0, tone, src}, 8'h00);
    t_mem();
    t_abort();
    t_cmds();
    t_tone();
    t_alert();
    t_wdt();
    t_reset();
    report_and_stop();
  end
  initial
  begin
    repeat (60000) @(posedge clock_i);
    num_errors++;
    report_and_stop();
  end
endmodule // segment_lcd_serial_controller_tb_top
